//--- dv/irtp_read_engine_assertions.sv
// checker for the i2c read text engine ports
`timescale 1ns/1ns
module irtp_read_engine_chk
(
	input wire logic mclk, // system clock
	input wire logic reset, // sync reset
	input wire logic link_clk, // link clock
	input wire logic bus_read_command, // start pulse
	input wire logic [7:0] read_length, // bytes to read
	input wire logic scl_o, // clock level
	input wire logic scl_oe, // clock pulled low
	input wire logic sda_o, // data level
	input wire logic sda_oe, // data pulled low
	input wire logic busy, // in progress
	input wire logic done, // finished pulse
	input wire logic timeout, // never acked
	input wire logic rx_valid, // byte pulse
	input wire logic conv_valid // number pulse
);
	// ==========
	// helper counts per command
	logic [7:0] len_r; // length taken at start
	logic [7:0] rx_n_r; // bytes seen
	logic [1:0] cv_n_r; // numbers seen
	// cleared when a command is taken
	always_ff @(posedge mclk)
	begin
		if (reset || (bus_read_command && !busy))
		begin
			rx_n_r <= 8'h00;
			cv_n_r <= 2'h0;
			len_r <= read_length;
		end
		else
		begin
			rx_n_r <= rx_n_r + {7'h00, rx_valid};
			cv_n_r <= cv_n_r + {1'b0, conv_valid};
		end
	end
	// ==========
	// steps of the command end and of a clock low phase
	sequence s_end;
		!busy ##1 !done;
	endsequence
	sequence s_low_held;
		scl_oe [*2];
	endsequence
	AST_BUSY_ON: assert property (@(posedge mclk) disable iff (reset)
		bus_read_command && !busy |=> busy) else $error("busy not raised");
	AST_DONE_END: assert property (@(posedge mclk) disable iff (reset)
		done |-> s_end) else $error("done not a single pulse at end");
	AST_BUSY_FALL: assert property (@(posedge mclk) disable iff (reset)
		$fell(busy) |-> done) else $error("busy dropped without done");
	AST_LINES_FREE: assert property (@(posedge mclk) disable iff (reset)
		!busy |-> !scl_oe && !sda_oe) else $error("line held while idle");
	AST_OPEN_DRAIN: assert property (@(posedge mclk) disable iff (reset)
		!scl_o && !sda_o) else $error("line driven high");
	AST_RX_IN_CMD: assert property (@(posedge mclk) disable iff (reset)
		rx_valid |-> busy ##1 !rx_valid) else $error("byte pulse outside command");
	AST_CONV_ONCE: assert property (@(posedge mclk) disable iff (reset)
		conv_valid |-> cv_n_r == 2'h0) else $error("second number in one command");
	AST_RX_COUNT: assert property (@(posedge mclk) disable iff (reset)
		done && !timeout |-> rx_n_r == len_r) else $error("wrong byte count");
	AST_TMO_EMPTY: assert property (@(posedge mclk) disable iff (reset)
		done && timeout |-> rx_n_r == 8'h00 && !conv_valid) else $error("data after timeout");
	AST_TMO_HOLD: assert property (@(posedge mclk) disable iff (reset)
		timeout && !busy && !bus_read_command |=> timeout) else $error("timeout dropped");
	AST_SCL_LOW: assert property (@(posedge link_clk) disable iff (reset)
		$rose(scl_oe) |=> s_low_held) else $error("clock low phase too short");
endmodule : irtp_read_engine_chk

bind irtp_read_engine irtp_read_engine_chk chk_u (.mclk, .reset, .link_clk, .bus_read_command,
	.read_length, .scl_o, .scl_oe, .sda_o, .sda_oe, .busy, .done, .timeout, .rx_valid, .conv_valid);

//--- dv/irtp_read_engine_tb.sv
// self-checking bench for the i2c read text engine
`timescale 1ns/1ns
module irtp_read_engine_tb
	import irtp_pkg::*;
;
	// ==========
	// stimulus rows
	typedef struct packed {irtp_conv_t m; logic [4:0] l; logic [63:0] s; logic [15:0] v; logic ok;} irtp_row_t;
	irtp_row_t rows [23] = '{
		'{cv_base10_text, 5'h00, "ab123   ", 16'h007b, 1'b1},
		'{cv_base10_text, 5'h02, "98765   ", 16'h0062, 1'b1},
		'{cv_base10_text, 5'h00, "1234567 ", 16'h3039, 1'b1},
		'{cv_base10_text, 5'h00, "abcdefgh", 16'h3039, 1'b0},
		'{cv_signed_base10_text, 5'h00, "-12     ", 16'hfff4, 1'b1},
		'{cv_signed_base10_text, 5'h00, "- 7     ", 16'h0007, 1'b1},
		'{cv_base16_text, 5'h00, "zz3aF   ", 16'h03af, 1'b1},
		'{cv_base16_text, 5'h00, "12345   ", 16'h1234, 1'b1},
		'{cv_signed_base16_text, 5'h00, "-1b     ", 16'hffe5, 1'b1},
		'{cv_prefixed_base16_text, 5'h00, "12$Ab   ", 16'h00ab, 1'b1},
		'{cv_prefixed_base16_text, 5'h00, "$ $7f   ", 16'h007f, 1'b1},
		'{cv_signed_prefixed_base16_text, 5'h00, "-$1B45  ", 16'he4bb, 1'b1},
		'{cv_base2_text, 5'h03, "x11111  ", 16'h0007, 1'b1},
		'{cv_signed_base2_text, 5'h00, "-110    ", 16'hfffa, 1'b1},
		'{cv_prefixed_base2_text, 5'h00, "10%11   ", 16'h0003, 1'b1},
		'{cv_signed_prefixed_base2_text, 5'h00, "-%101   ", 16'hfffb, 1'b1},
		'{cv_any_base_text, 5'h00, "$1f     ", 16'h001f, 1'b1},
		'{cv_any_base_text, 5'h00, "%11     ", 16'h0003, 1'b1},
		'{cv_any_base_text, 5'h00, "42      ", 16'h002a, 1'b1},
		'{cv_signed_any_base_text, 5'h00, "-32768  ", 16'h8000, 1'b1},
		'{cv_signed_any_base_text, 5'h00, "-$10    ", 16'hfff0, 1'b1},
		'{cv_signed_any_base_text, 5'h00, "32767   ", 16'h7fff, 1'b1},
		'{cv_base10_text, 5'h00, "     678", 16'h02a6, 1'b1}
	};
	logic mclk, link_clk, reset, cmd, aen, alen, nak; // bench drives
	logic scl_o, scl_oe, sda_o, sda_oe, t_oe, busy, done, timeout, rx_valid, cv; // observed
	logic [7:0] id, ahi, alo, len, rx_data; // config and data
	logic [4:0] lim; // digit count
	logic [15:0] val, n_rx, n_cv, n_st; // value and tallies
	logic [63:0] text; // target contents
	irtp_conv_t mode; // conversion
	int n_errors, tests_run, cyc; // verdict counters
	wire scl = !scl_oe; // pulled-up clock line
	wire sda = !(sda_oe || t_oe); // pulled-up data line
	irtp_read_engine dut_u (.mclk(mclk), .reset(reset), .link_clk(link_clk), .bus_read_command(cmd),
		.target_id_byte(id), .inner_address_en(aen), .inner_address_high(ahi), .inner_address_low_en(alen),
		.inner_address_low(alo), .read_length(len), .conv_mode(mode), .digit_limit(lim), .scl_o(scl_o),
		.scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .busy(busy), .done(done),
		.timeout(timeout), .rx_data(rx_data), .rx_valid(rx_valid), .conv_value(val), .conv_valid(cv));
	irtp_target t_u (.scl(scl), .sda(sda), .nak_all(nak), .text(text), .sda_oe(t_oe));
	// ==========
	// clocks, unrelated phases
	initial
	begin
		mclk = 0;
		forever #5 mclk = ~mclk;
	end
	initial
	begin
		link_clk = 0;
		#7;
		forever #15 link_clk = ~link_clk;
	end
	// tallies and hang guard, outputs settled
	always @(negedge mclk)
	begin
		cyc++;
		if (rx_valid === 1'b1) n_rx++;
		if (cv === 1'b1) n_cv++;
		if (cyc == 90000)
		begin
			n_errors++;
			wrap_up();
		end
	end
	// start conditions on the wire
	always @(negedge sda)
		if (scl === 1'b1) n_st++;
	// ==========
	// tasks
	task chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		tests_run++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task wrap_up();
		if (n_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	// one command, waits for done
	task automatic go(input irtp_conv_t m, input logic [4:0] l, input logic [63:0] s);
		int k;
		@(negedge mclk);
		mode = m;
		lim = l;
		text = s;
		{n_rx, n_cv, n_st} = 0;
		cmd = 1'b1;
		@(negedge mclk);
		cmd = 1'b0;
		k = 0;
		while (done !== 1'b1 && k < 9000)
		begin
			@(negedge mclk);
			k++;
		end
		// one more edge so the tallies include the done cycle
		@(negedge mclk);
		chk(16'(k < 9000), 16'h0001, "done");
	endtask : go
	// ==========
	// main sequence
	initial
	begin
		{reset, cmd, aen, alen, nak, ahi, alo, lim, text} = 0;
		reset = 1'b1;
		aen = 1'b1;
		id = 8'ha1;
		len = 8'h08;
		mode = cv_base10_text;
		{n_errors, tests_run, cyc} = 0;
		{n_rx, n_cv, n_st} = 0;
		repeat (16) @(negedge mclk);
		chk({9'h000, busy, done, timeout, rx_valid, cv, scl_oe, sda_oe}, 16'h0000, "reset outputs");
		reset = 1'b0;
		repeat (20) @(negedge mclk);
		foreach (rows[i])
		begin
			go(rows[i].m, rows[i].l, rows[i].s);
			chk(val, rows[i].v, "value");
			chk(n_cv, {15'h0000, rows[i].ok}, "numbers");
			chk(n_rx, 16'h0008, "bytes");
			chk(n_st, 16'h0002, "starts");
			chk({8'h00, rx_data}, {8'h00, rows[i].s[7:0]}, "last byte");
			chk({15'h0000, timeout}, 16'h0000, "no timeout");
		end
		// two-byte inner address, low byte last
		ahi = 8'h05;
		alen = 1'b1;
		alo = 8'h02;
		go(cv_base10_text, 5'h00, "12 34 5 ");
		chk(val, 16'h0022, "long address");
		// no inner address, id bit 0 given as write
		{aen, alen} = 0;
		id = 8'ha0;
		go(cv_base10_text, 5'h00, "12 34 5 ");
		chk(n_st, 16'h0001, "single start");
		chk(n_cv, 16'h0001, "read done");
		// refused id, attempts then timeout
		aen = 1'b1;
		nak = 1'b1;
		go(cv_base10_text, 5'h00, "99999999");
		chk({15'h0000, timeout}, 16'h0001, "timeout");
		chk(n_st, 16'h0008, "attempts");
		chk(n_rx, 16'h0000, "no data");
		chk(val, 16'h0022, "held value");
		wrap_up();
	end
endmodule : irtp_read_engine_tb

//--- dv/irtp_target.sv
// behavioural i2c target holding eight text bytes
`timescale 1ns/1ns
module irtp_target
#(
	parameter logic [6:0] TID = 7'h50 // answering id
)
(
	input wire logic scl, // clock line
	input wire logic sda, // data line
	input wire logic nak_all, // refuse every id
	input wire logic [63:0] text, // stored bytes
	output logic sda_oe // pulls data low
);
	// ==========
	// framing state
	logic [3:0] cnt; // clocks in byte
	logic [7:0] sh; // received byte
	logic [7:0] cur; // byte sent
	logic [2:0] ptr; // byte pointer
	logic first, act, go, rd, mack; // phase flags
	initial
	begin
		{cnt, ptr, sda_oe, rd, first, act, go, mack} = 0;
	end
	// start restarts framing
	always @(negedge sda)
		if (scl)
		begin
			cnt = 0;
			first = 1;
			rd = 0;
			sda_oe = 0;
		end
	// stop ends the session
	always @(posedge sda)
		if (scl)
		begin
			rd = 0;
			act = 0;
		end
	// sample while clock high
	always @(posedge scl)
	begin
		if (cnt < 8)
			sh = {sh[6:0], sda};
		else
			mack = !sda; // master answer on ninth clock
		cnt = cnt + 1;
	end
	// drive while clock low
	always @(negedge scl)
	begin
		if (cnt == 8 && !rd)
		begin
			if (first)
			begin
				act = (sh[7:1] == TID) && !nak_all;
				go = act && sh[0];
			end
			else if (act)
				ptr = sh[2:0];
			first = 0;
			sda_oe = act;
		end
		else if (cnt == 9)
		begin
			cnt = 0;
			sda_oe = 0;
			if (go)
			begin
				rd = 1;
				mack = 1;
				go = 0;
			end
			if (rd && mack)
			begin
				cur = text[63 - 8 * ptr -: 8];
				ptr = ptr + 1;
				sda_oe = !cur[7];
			end
			else
				rd = 0; // nack ends the stream
		end
		else if (rd && cnt < 8)
			sda_oe = !cur[7 - cnt];
		else if (rd)
			sda_oe = 0; // free for master answer
	end
endmodule : irtp_target

//--- hdl/irtp_read_engine.sv
// i2c combined-format read engine with numeric text parser
// Notes on behaviour
// - conversion ends at digit limit or non-digit
// - digit limits 5, 4 and 16 per base
// - minus counts only when a digit follows
// - hex letters accepted in either case
// - prefixed modes discard all until prefix
// - prefix dropped if non-digit follows it
// - signed prefixed: minus comes before prefix
// - any-base mode takes base from prefix
// - signed any-base yields signed 16-bit value
// - bus moves whole 8-bit bytes
// - first byte: 7-bit id plus direction
// - optional inner address byte after id
// - receive configured number of data bytes
// - start condition opens, stop closes
// - ninth clock carries the acknowledge
// - read with inner address sends id write, address, id read; without it, id read only
// - single master, never a target
// - up to 8 attempts, then timeout
// - both lines released when command ends
`timescale 1ns/1ns
`include "irtp_defs.svh"

module irtp_read_engine
	import irtp_pkg::*;
(
	input wire logic mclk, // system clock
	input wire logic reset, // synchronous reset, high
	input wire logic link_clk, // clock of the link, eight per bit
	input wire logic bus_read_command, // pulse: start a read
	input wire logic [7:0] target_id_byte, // target id, bit 0 ignored
	input wire logic inner_address_en, // send an inner address
	input wire logic [7:0] inner_address_high, // inner address (high)
	input wire logic inner_address_low_en, // send a low address byte
	input wire logic [7:0] inner_address_low, // low address byte
	input wire logic [7:0] read_length, // data bytes to read
	input wire irtp_conv_t conv_mode, // text conversion mode
	input wire logic [4:0] digit_limit, // digit count, 0 = maximum
	output logic scl_o, // clock pin level when driven
	output logic scl_oe, // clock pin pulled low
	input wire logic sda_i, // data pin level
	output logic sda_o, // data pin level when driven
	output logic sda_oe, // data pin pulled low
	output logic busy, // command in progress
	output logic done, // pulse: command finished
	output logic timeout, // target never acknowledged
	output logic [7:0] rx_data, // last received byte
	output logic rx_valid, // pulse: rx_data new
	output logic [15:0] conv_value, // converted number
	output logic conv_valid // pulse: conv_value new
);

	// ==========================================
	// helper functions
	// ==========================================

	// digit check: {valid, value}
	function automatic logic [4:0] digit_of(input logic [7:0] c, input irtp_base_t b);
		logic [4:0] r;
		r = 5'h00;
		if (c >= `IRTP_CH_0 && c <= `IRTP_CH_9)
		begin
			if (b != bs_2 || c <= `IRTP_CH_1)
				r = {1'b1, 4'(c - `IRTP_CH_0)};
		end
		else if (b == bs_16 && c >= `IRTP_CH_UA && c <= `IRTP_CH_UF)
			r = {1'b1, 4'(c - `IRTP_CH_UA + `IRTP_HEX_TEN)};
		else if (b == bs_16 && c >= `IRTP_CH_LA && c <= `IRTP_CH_LF)
			r = {1'b1, 4'(c - `IRTP_CH_LA + `IRTP_HEX_TEN)};
		return r;
	endfunction : digit_of

	// mode decode: {signed, prefixed, any, base}
	function automatic logic [4:0] mode_of(input irtp_conv_t m);
		logic [4:0] r;
		r = {3'b000, bs_10};
		case (m)
			cv_signed_base10_text: r = {3'b100, bs_10};
			cv_base16_text: r = {3'b000, bs_16};
			cv_signed_base16_text: r = {3'b100, bs_16};
			cv_prefixed_base16_text: r = {3'b010, bs_16};
			cv_signed_prefixed_base16_text: r = {3'b110, bs_16};
			cv_base2_text: r = {3'b000, bs_2};
			cv_signed_base2_text: r = {3'b100, bs_2};
			cv_prefixed_base2_text: r = {3'b010, bs_2};
			cv_signed_prefixed_base2_text: r = {3'b110, bs_2};
			cv_any_base_text: r = {3'b001, bs_10};
			cv_signed_any_base_text: r = {3'b101, bs_10};
			default: r = {3'b000, bs_10};
		endcase
		return r;
	endfunction : mode_of

	// effective digit count for a base
	function automatic logic [4:0] lim_of(input irtp_base_t b, input logic [4:0] l);
		logic [4:0] mx;
		mx = `IRTP_MAXDIG_B10;
		if (b == bs_16)
			mx = `IRTP_MAXDIG_B16;
		else if (b == bs_2)
			mx = `IRTP_MAXDIG_B2;
		return (l == 5'h00 || l > mx) ? mx : l;
	endfunction : lim_of

	// byte sent for each step
	function automatic logic [7:0] tx_of(input irtp_step_t s, input irtp_main_t m);
		logic [7:0] r;
		r = {m.id[7:1], `IRTP_DIR_RD};
		if (s == sp_id_wr)
			r = {m.id[7:1], `IRTP_DIR_WR};
		else if (s == sp_addr_hi)
			r = m.ahi;
		else if (s == sp_addr_lo)
			r = m.alo;
		return r;
	endfunction : tx_of

	// ==========================================
	// state registers
	// ==========================================

	irtp_link_t l_r; // link domain state
	irtp_link_t l_nxt; // its next value
	irtp_main_t m_r; // system domain state
	irtp_main_t m_nxt; // its next value
	logic lrst1_r; // reset sync, first stage
	logic lrst2_r; // reset in link domain

	// reset carried into the link domain
	always_ff @(posedge link_clk)
	begin
		lrst1_r <= reset;
		lrst2_r <= lrst1_r;
	end

	// ==========================================
	// link engine
	// ==========================================

	// bus sequencing, one bit every eight link clocks
	always_comb
	begin
		l_nxt = l_r;
		l_nxt.go1 = m_r.start_tgl; // start toggle sync
		l_nxt.go2 = l_r.go1;
		l_nxt.go3 = l_r.go2;
		l_nxt.sd1 = sda_i; // data pin sync
		l_nxt.sd2 = l_r.sd1;
		l_nxt.q = l_r.q + 3'h1;
		case (l_r.st)
			ls_idle:
			begin
				// lines released, only ever a master
				l_nxt.q = 3'h0;
				l_nxt.scl_low = 1'b0;
				l_nxt.sda_low = 1'b0;
				if (l_r.go2 ^ l_r.go3)
				begin
					l_nxt.tries = 4'h0;
					l_nxt.tmo = 1'b0;
					l_nxt.nak = 1'b0;
					l_nxt.rep = 1'b0;
					l_nxt.remain = m_r.len;
					l_nxt.step = m_r.aen ? sp_id_wr : sp_id_rd;
					l_nxt.st = ls_start;
				end
			end
			ls_start:
			begin
				// sda falls while scl is high
				l_nxt.scl_low = l_r.rep && l_r.q < `IRTP_Q_SCLHI;
				l_nxt.sda_low = l_r.q >= `IRTP_Q_SDALO;
				if (l_r.q == `IRTP_Q_END)
				begin
					l_nxt.st = ls_byte;
					l_nxt.bidx = 4'h0;
					l_nxt.sh = tx_of(l_r.step, m_r);
				end
			end
			ls_byte:
			begin
				l_nxt.scl_low = l_r.q < `IRTP_Q_SCLHI;
				// data changes only while scl is low
				if (l_r.q == `IRTP_Q_SDA)
				begin
					if (l_r.step != sp_data)
						l_nxt.sda_low = (l_r.bidx < `IRTP_ACK_BIT) && !l_r.sh[7];
					else
						l_nxt.sda_low = (l_r.bidx == `IRTP_ACK_BIT) && (l_r.remain != 8'h01);
				end
				if (l_r.q == `IRTP_Q_END && l_r.bidx < `IRTP_ACK_BIT)
				begin
					// eight bits, msb first
					l_nxt.sh = {l_r.sh[6:0], l_r.sd2};
					l_nxt.bidx = l_r.bidx + 4'h1;
				end
				else if (l_r.q == `IRTP_Q_END && l_r.step != sp_data)
				begin
					// acknowledge sampled from the target
					if (l_r.sd2)
					begin
						l_nxt.nak = 1'b1;
						l_nxt.tries = l_r.tries + 4'h1;
						l_nxt.st = ls_stop;
					end
					else
					begin
						l_nxt.bidx = 4'h0;
						case (l_r.step)
							sp_id_wr:
							begin
								l_nxt.step = sp_addr_hi;
								l_nxt.sh = m_r.ahi;
							end
							sp_addr_hi:
							begin
								if (m_r.alen)
								begin
									l_nxt.step = sp_addr_lo;
									l_nxt.sh = m_r.alo;
								end
								else
								begin
									l_nxt.step = sp_id_rd;
									l_nxt.rep = 1'b1;
									l_nxt.st = ls_start;
								end
							end
							sp_addr_lo:
							begin
								l_nxt.step = sp_id_rd;
								l_nxt.rep = 1'b1;
								l_nxt.st = ls_start;
							end
							sp_id_rd:
							begin
								l_nxt.step = sp_data;
								if (l_r.remain == 8'h00)
									l_nxt.st = ls_stop;
							end
							default: l_nxt.st = ls_stop;
						endcase
					end
				end
				else if (l_r.q == `IRTP_Q_END)
				begin
					// data byte complete, hand it over
					l_nxt.rxd = l_r.sh;
					l_nxt.byte_tgl = !l_r.byte_tgl;
					l_nxt.remain = l_r.remain - 8'h01;
					l_nxt.bidx = 4'h0;
					if (l_r.remain == 8'h01)
						l_nxt.st = ls_stop;
				end
			end
			ls_stop:
			begin
				// sda rises while scl is high
				l_nxt.scl_low = l_r.q < `IRTP_Q_SCLHI;
				l_nxt.sda_low = l_r.q >= `IRTP_Q_SDA && l_r.q < `IRTP_Q_SDALO;
				if (l_r.q == `IRTP_Q_END)
				begin
					if (l_r.nak && l_r.tries != `IRTP_TRIES)
					begin
						// another connection attempt
						l_nxt.nak = 1'b0;
						l_nxt.rep = 1'b0;
						l_nxt.remain = m_r.len;
						l_nxt.step = m_r.aen ? sp_id_wr : sp_id_rd;
						l_nxt.st = ls_start;
					end
					else
					begin
						l_nxt.tmo = l_r.nak;
						l_nxt.done_tgl = !l_r.done_tgl;
						l_nxt.st = ls_idle;
					end
				end
			end
			default: l_nxt.st = ls_idle;
		endcase
	end

	// link state register
	always_ff @(posedge link_clk)
	begin
		if (lrst2_r)
		begin
			l_r <= '0;
			l_r.st <= ls_idle;
			l_r.step <= sp_id_wr;
		end
		else
			l_r <= l_nxt;
	end

	// ==========================================
	// command and text parser
	// ==========================================

	// command control and numeric conversion
	always_comb
	begin
		logic [4:0] mf; // mode flags
		logic [4:0] mc; // mode flags of a new command
		logic [4:0] dg; // digit decode
		logic [7:0] c; // received character
		logic [4:0] lim; // digit limit
		logic [15:0] acc0; // accumulator base
		logic [15:0] accn; // accumulator after digit
		logic pfx16, pfx2, take, fin;
		m_nxt = m_r;
		mf = mode_of(m_r.mode);
		mc = mode_of(conv_mode);
		c = l_r.rxd;
		dg = digit_of(c, m_r.base);
		lim = lim_of(m_r.base, m_r.lim);
		acc0 = (m_r.ps == ps_digits) ? m_r.acc : 16'h0000;
		accn = {acc0[12:0], 3'b000} + {acc0[14:0], 1'b0} + {12'h000, dg[3:0]};
		if (m_r.base == bs_16)
			accn = {acc0[11:0], dg[3:0]};
		else if (m_r.base == bs_2)
			accn = {acc0[14:0], dg[0]};
		pfx16 = c == `IRTP_CH_DOLLAR && (mf[2] || (mf[3] && mf[1:0] == bs_16));
		pfx2 = c == `IRTP_CH_PCT && (mf[2] || (mf[3] && mf[1:0] == bs_2));
		take = 1'b0;
		fin = 1'b0;
		m_nxt.b1 = l_r.byte_tgl; // byte event sync
		m_nxt.b2 = m_r.b1;
		m_nxt.b3 = m_r.b2;
		m_nxt.d1 = l_r.done_tgl; // done event sync
		m_nxt.d2 = m_r.d1;
		m_nxt.d3 = m_r.d2;
		m_nxt.done = 1'b0;
		m_nxt.rx_valid = 1'b0;
		m_nxt.val_ok = 1'b0;
		// new command, ignored while busy
		if (bus_read_command && !m_r.busy)
		begin
			m_nxt.busy = 1'b1;
			m_nxt.timeout = 1'b0;
			m_nxt.start_tgl = !m_r.start_tgl;
			m_nxt.id = target_id_byte;
			m_nxt.aen = inner_address_en;
			m_nxt.ahi = inner_address_high;
			m_nxt.alen = inner_address_en && inner_address_low_en;
			m_nxt.alo = inner_address_low;
			m_nxt.len = read_length;
			m_nxt.mode = conv_mode;
			m_nxt.lim = digit_limit;
			m_nxt.ps = ps_scan;
			m_nxt.neg = 1'b0;
			m_nxt.acc = 16'h0000;
			m_nxt.ndig = 5'h00;
			m_nxt.base = mc[2] ? bs_10 : irtp_base_t'(mc[1:0]);
		end
		// one received character
		if (m_r.b2 ^ m_r.b3)
		begin
			m_nxt.rxd = c;
			m_nxt.rx_valid = 1'b1;
			case (m_r.ps)
				ps_scan:
				begin
					if (mf[4] && c == `IRTP_CH_MINUS)
					begin
						m_nxt.ps = ps_minus;
						m_nxt.neg = 1'b1;
					end
					else if (pfx16 || pfx2)
					begin
						m_nxt.ps = ps_prefix;
						m_nxt.base = pfx16 ? bs_16 : bs_2;
					end
					else if (!mf[3] && dg[4])
						take = 1'b1;
				end
				ps_minus:
				begin
					if (pfx16 || pfx2)
					begin
						m_nxt.ps = ps_prefix;
						m_nxt.base = pfx16 ? bs_16 : bs_2;
					end
					else if (!mf[3] && dg[4])
						take = 1'b1;
					else if (c != `IRTP_CH_MINUS)
					begin
						m_nxt.ps = ps_scan;
						m_nxt.neg = 1'b0;
					end
				end
				ps_prefix:
				begin
					if (dg[4])
						take = 1'b1;
					else
					begin
						m_nxt.ps = ps_scan;
						m_nxt.neg = 1'b0;
						m_nxt.base = mf[2] ? bs_10 : irtp_base_t'(mf[1:0]);
					end
				end
				ps_digits:
				begin
					if (dg[4])
						take = 1'b1;
					else
						fin = 1'b1;
				end
				ps_done: m_nxt.ps = ps_done;
				default: m_nxt.ps = ps_scan;
			endcase
			if (take)
			begin
				m_nxt.acc = accn;
				m_nxt.ndig = (m_r.ps == ps_digits) ? m_r.ndig + 5'h01 : 5'h01;
				m_nxt.ps = ps_digits;
				if (m_nxt.ndig == lim)
					fin = 1'b1;
			end
		end
		// command finished on the link
		if (m_r.d2 ^ m_r.d3)
		begin
			m_nxt.busy = 1'b0;
			m_nxt.done = 1'b1;
			m_nxt.timeout = l_r.tmo;
			if (m_nxt.ps == ps_digits)
				fin = 1'b1;
		end
		// publish the number, value kept otherwise
		if (fin)
		begin
			m_nxt.ps = ps_done;
			m_nxt.val_ok = 1'b1;
			m_nxt.value = m_nxt.neg ? 16'h0000 - m_nxt.acc : m_nxt.acc;
		end
	end

	// system state register
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			m_r <= '0;
			m_r.ps <= ps_scan;
		end
		else
			m_r <= m_nxt;
	end

	// ==========================================
	// outputs
	// ==========================================

	assign scl_o = l_r.lvl;
	assign scl_oe = l_r.scl_low;
	assign sda_o = l_r.lvl;
	assign sda_oe = l_r.sda_low;
	assign busy = m_r.busy;
	assign done = m_r.done;
	assign timeout = m_r.timeout;
	assign rx_data = m_r.rxd;
	assign rx_valid = m_r.rx_valid;
	assign conv_value = m_r.value;
	assign conv_valid = m_r.val_ok;

endmodule : irtp_read_engine

//--- inc/irtp_defs.svh
// constants for the i2c read text engine
`ifndef IRTP_DEFS_SVH
`define IRTP_DEFS_SVH
// characters seen by the text parser
`define IRTP_CH_MINUS 8'h2d
`define IRTP_CH_DOLLAR 8'h24
`define IRTP_CH_PCT 8'h25
`define IRTP_CH_0 8'h30
`define IRTP_CH_1 8'h31
`define IRTP_CH_9 8'h39
`define IRTP_CH_UA 8'h41
`define IRTP_CH_UF 8'h46
`define IRTP_CH_LA 8'h61
`define IRTP_CH_LF 8'h66
`define IRTP_HEX_TEN 8'h0a
// digit limits per base
`define IRTP_MAXDIG_B10 5'h05
`define IRTP_MAXDIG_B16 5'h04
`define IRTP_MAXDIG_B2 5'h10
// connection attempts before timeout
`define IRTP_TRIES 4'h8
// bit phases, eight link clocks per bit
`define IRTP_Q_SCLHI 3'h3
`define IRTP_Q_SDA 3'h1
`define IRTP_Q_SDALO 3'h6
`define IRTP_Q_END 3'h7
`define IRTP_ACK_BIT 4'h8
`define IRTP_DIR_WR 1'b0
`define IRTP_DIR_RD 1'b1
`endif

//--- inc/irtp_pkg.sv
// types for the i2c read text engine
package irtp_pkg;
	// text conversion modes
	typedef enum logic [3:0] {
		cv_base10_text = 4'h0,
		cv_signed_base10_text = 4'h1,
		cv_base16_text = 4'h2,
		cv_signed_base16_text = 4'h3,
		cv_prefixed_base16_text = 4'h4,
		cv_signed_prefixed_base16_text = 4'h5,
		cv_base2_text = 4'h6,
		cv_signed_base2_text = 4'h7,
		cv_prefixed_base2_text = 4'h8,
		cv_signed_prefixed_base2_text = 4'h9,
		cv_any_base_text = 4'ha,
		cv_signed_any_base_text = 4'hb
	} irtp_conv_t;
	typedef enum logic [1:0] {bs_10 = 2'h0, bs_16 = 2'h1, bs_2 = 2'h2} irtp_base_t;
	// link engine states
	typedef enum logic [3:0] {ls_idle = 4'h1, ls_start = 4'h2, ls_byte = 4'h4, ls_stop = 4'h8} irtp_lst_t;
	// byte being moved on the bus
	typedef enum logic [4:0] {
		sp_id_wr = 5'h01, sp_addr_hi = 5'h02, sp_addr_lo = 5'h04, sp_id_rd = 5'h08, sp_data = 5'h10
	} irtp_step_t;
	// parser states
	typedef enum logic [4:0] {
		ps_scan = 5'h01, ps_minus = 5'h02, ps_prefix = 5'h04, ps_digits = 5'h08, ps_done = 5'h10
	} irtp_pst_t;
	// link domain state
	typedef struct packed {
		irtp_lst_t st;
		irtp_step_t step;
		logic [2:0] q;
		logic [3:0] bidx;
		logic [7:0] sh;
		logic rep;
		logic nak;
		logic [3:0] tries;
		logic [7:0] remain;
		logic [7:0] rxd;
		logic byte_tgl;
		logic done_tgl;
		logic tmo;
		logic scl_low;
		logic sda_low;
		logic lvl;
		logic go1, go2, go3;
		logic sd1, sd2;
	} irtp_link_t;
	// system domain state
	typedef struct packed {
		logic busy, done, timeout, start_tgl;
		logic [7:0] id;
		logic aen;
		logic [7:0] ahi;
		logic alen;
		logic [7:0] alo;
		logic [7:0] len;
		irtp_conv_t mode;
		logic [4:0] lim;
		logic b1, b2, b3, d1, d2, d3;
		logic [7:0] rxd;
		logic rx_valid;
		irtp_pst_t ps;
		logic neg;
		irtp_base_t base;
		logic [15:0] acc;
		logic [4:0] ndig;
		logic [15:0] value;
		logic val_ok;
	} irtp_main_t;
endpackage : irtp_pkg
